//--- common/fbas_pkg.sv
// Operation
// - sixteen four-bit words, two simultaneous read ports
// - nine-bit word: source, function, destination
// - eight functions: add, two subtracts, five logic
// - first address selects A port word
// - second address selects B word, written
// - Q and stack change on rising edge
// - reads held stable while stack written
// - left shift drives MSB lines, else released
// - right shift takes MSB lines as inputs
// - LSB lines mirror MSB lines, opposite direction
// - direct operand selectable as ALU source
// - Y shows ALU result or A data
// - Y driven only while enable low
// - active-low generate and propagate for lookahead
// - overflow is carry-in XOR carry-out of MSB
// - zero line released when result zero
// - ripple or lookahead cascade, carries active high
// - shift independent of function, one cycle
// - source codes pick R and S operands
// - function codes pick ALU operation
// - stack write goes to B, shift mux
package fbas_pkg;

  // ****************************************
  // widths and field positions
  // ****************************************
  localparam int WORD_W   = 4;
  localparam int DEPTH    = 16;
  localparam int ADDR_W   = 4;
  localparam int INSTR_W  = 9;
  localparam int FIELD_W  = 3;
  localparam int SRC_LSB  = 0;
  localparam int FUNC_LSB = 3;
  localparam int DEST_LSB = 6;
  localparam int MSB      = WORD_W - 1;

  localparam logic [WORD_W-1:0] ZERO_WORD = 4'h0;
  localparam int                CLK_PERIOD_NS = 20;

  // ****************************************
  // microinstruction codes
  // ****************************************
  typedef enum logic [2:0] {
    SRC_AQ = 3'h0,
    SRC_AB = 3'h1,
    SRC_ZQ = 3'h2,
    SRC_ZB = 3'h3,
    SRC_ZA = 3'h4,
    SRC_DA = 3'h5,
    SRC_DQ = 3'h6,
    SRC_DZ = 3'h7
  } fbas_src_t;

  typedef enum logic [2:0] {
    FN_ADD  = 3'h0,
    FN_SUBR = 3'h1,
    FN_SUBS = 3'h2,
    FN_OR   = 3'h3,
    FN_AND  = 3'h4,
    FN_NOTRS = 3'h5,
    FN_XOR  = 3'h6,
    FN_XNOR = 3'h7
  } fbas_func_t;

  typedef enum logic [2:0] {
    DST_QREG = 3'h0,
    DST_NOP  = 3'h1,
    DST_RAMA = 3'h2,
    DST_RAMF = 3'h3,
    DST_RAMQD = 3'h4,
    DST_RAMD = 3'h5,
    DST_RAMQU = 3'h6,
    DST_RAMU = 3'h7
  } fbas_dest_t;

  typedef enum logic [1:0] {
    SH_NONE = 2'h0,
    SH_DOWN = 2'h1,
    SH_UP   = 2'h2
  } fbas_shift_t;

  typedef enum logic [1:0] {
    QM_HOLD = 2'h0,
    QM_LOAD = 2'h1,
    QM_DOWN = 2'h2,
    QM_UP   = 2'h3
  } fbas_qmode_t;

endpackage

//--- rtl/fbas_regstack.sv
`timescale 1ns/10ps
module fbas_regstack (
  input  wire logic                        i_mclk,
  input  wire logic [fbas_pkg::ADDR_W-1:0] i_addr_a,
  input  wire logic [fbas_pkg::ADDR_W-1:0] i_addr_b,
  input  wire logic                        i_wr_en,
  input  wire logic [fbas_pkg::WORD_W-1:0] i_wr_data,
  output logic      [fbas_pkg::WORD_W-1:0] o_rd_a,
  output logic      [fbas_pkg::WORD_W-1:0] o_rd_b
);
  import fbas_pkg::*;

  // ****************************************
  // storage
  // ****************************************
  logic [WORD_W-1:0] mem_q [DEPTH];

  // contents stay undefined until written
  always_ff @(posedge i_mclk) begin
    if (i_wr_en) begin
      mem_q[i_addr_b] <= i_wr_data;
    end
  end

  // ****************************************
  // read ports
  // ****************************************
  // reads see the old word all cycle; the write lands at the edge
  always_comb begin
    o_rd_a = mem_q[i_addr_a];
    o_rd_b = mem_q[i_addr_b];
  end

endmodule // fbas_regstack

//--- rtl/fbas_slice.sv
`timescale 1ns/10ps
module fbas_slice (
  input  wire logic                         i_mclk,
  input  wire logic [fbas_pkg::ADDR_W-1:0]  i_first_read_address,
  input  wire logic [fbas_pkg::ADDR_W-1:0]  i_second_read_write_address,
  input  wire logic [fbas_pkg::INSTR_W-1:0] i_microinstruction_word,
  input  wire logic [fbas_pkg::WORD_W-1:0]  i_direct_operand_in,
  input  wire logic                         i_carry_input,
  input  wire logic                         i_output_enable_b,
  input  wire logic                         i_stack_msb_shift_line,
  output logic                              o_stack_msb_shift_line,
  output logic                              o_stack_msb_shift_line_oe,
  input  wire logic                         i_accumulator_msb_shift_line,
  output logic                              o_accumulator_msb_shift_line,
  output logic                              o_accumulator_msb_shift_line_oe,
  input  wire logic                         i_stack_lsb_shift_line,
  output logic                              o_stack_lsb_shift_line,
  output logic                              o_stack_lsb_shift_line_oe,
  input  wire logic                         i_accumulator_lsb_shift_line,
  output logic                              o_accumulator_lsb_shift_line,
  output logic                              o_accumulator_lsb_shift_line_oe,
  output logic      [fbas_pkg::WORD_W-1:0]  o_slice_result_out,
  output logic                              o_slice_result_out_oe,
  output logic                              o_carry_output,
  output logic                              o_carry_generate_b,
  output logic                              o_carry_propagate_b,
  output logic                              o_overflow_flag,
  output logic                              o_alu_sign,
  output logic                              o_zero_detect,
  output logic                              o_zero_detect_oe
);
  import fbas_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [FIELD_W-1:0] fbas_field(
    input logic [INSTR_W-1:0] word,
    input int                 lsb
  );
    fbas_field = word[lsb +: FIELD_W];
  endfunction

  // returns {generate, propagate} of a four-bit group
  function automatic logic [1:0] fbas_lookahead(
    input logic [WORD_W-1:0] gen,
    input logic [WORD_W-1:0] prop
  );
    logic grp_g;
    logic grp_p;
    grp_g = gen[3]
          | (prop[3] & gen[2])
          | (prop[3] & prop[2] & gen[1])
          | (prop[3] & prop[2] & prop[1] & gen[0]);
    grp_p = &prop;
    fbas_lookahead = {grp_g, grp_p};
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  fbas_src_t         src_sel;
  fbas_func_t        func_sel;
  fbas_dest_t        dest_sel;

  logic [WORD_W-1:0] port_a;
  logic [WORD_W-1:0] port_b;
  logic [WORD_W-1:0] acc_q;
  logic [WORD_W-1:0] acc_d;

  logic [WORD_W-1:0] opnd_r;
  logic [WORD_W-1:0] opnd_s;
  logic [WORD_W-1:0] arith_r;
  logic [WORD_W-1:0] arith_s;
  logic              is_arith;
  logic [WORD_W:0]   arith_sum;
  logic [MSB:0]      low_sum;
  logic              carry_into_msb;
  logic [WORD_W-1:0] bit_gen;
  logic [WORD_W-1:0] bit_prop;
  logic [1:0]        group_gp;
  logic [WORD_W-1:0] alu_f;

  fbas_shift_t       ram_shift;
  fbas_qmode_t       acc_mode;
  logic              ram_wr;
  logic              y_from_a;
  logic [WORD_W-1:0] ram_wr_data;

  // ****************************************
  // microinstruction fields
  // ****************************************
  always_comb begin
    src_sel  = fbas_src_t'(fbas_field(i_microinstruction_word, SRC_LSB));
    func_sel = fbas_func_t'(fbas_field(i_microinstruction_word, FUNC_LSB));
    dest_sel = fbas_dest_t'(fbas_field(i_microinstruction_word, DEST_LSB));
  end

  // ****************************************
  // register stack
  // ****************************************
  fbas_regstack u_regstack (
    .i_mclk    (i_mclk),
    .i_addr_a  (i_first_read_address),
    .i_addr_b  (i_second_read_write_address),
    .i_wr_en   (ram_wr),
    .i_wr_data (ram_wr_data),
    .o_rd_a    (port_a),
    .o_rd_b    (port_b)
  );

  // ****************************************
  // operand selection
  // ****************************************
  // an unselected operand is held at zero, the inhibit case
  always_comb begin
    opnd_r = ZERO_WORD;
    opnd_s = ZERO_WORD;
    case (src_sel)
      SRC_AQ: begin
        opnd_r = port_a;
        opnd_s = acc_q;
      end
      SRC_AB: begin
        opnd_r = port_a;
        opnd_s = port_b;
      end
      SRC_ZQ: begin
        opnd_s = acc_q;
      end
      SRC_ZB: begin
        opnd_s = port_b;
      end
      SRC_ZA: begin
        opnd_s = port_a;
      end
      SRC_DA: begin
        opnd_r = i_direct_operand_in;
        opnd_s = port_a;
      end
      SRC_DQ: begin
        opnd_r = i_direct_operand_in;
        opnd_s = acc_q;
      end
      default: begin
        opnd_r = i_direct_operand_in;
      end
    endcase
  end

  // ****************************************
  // arithmetic path
  // ****************************************
  // subtraction is addition of a complement plus carry-in
  always_comb begin
    arith_r  = opnd_r;
    arith_s  = opnd_s;
    is_arith = 1'b1;
    case (func_sel)
      FN_ADD: begin
        arith_r = opnd_r;
      end
      FN_SUBR: begin
        arith_r = ~opnd_r;
      end
      FN_SUBS: begin
        arith_s = ~opnd_s;
      end
      default: begin
        is_arith = 1'b0;
      end
    endcase
  end

  always_comb begin
    arith_sum = {1'b0, arith_r} + {1'b0, arith_s} + {4'h0, i_carry_input};
    low_sum   = {1'b0, arith_r[MSB-1:0]} + {1'b0, arith_s[MSB-1:0]} + {3'h0, i_carry_input};
    carry_into_msb = low_sum[MSB];
    bit_gen   = arith_r & arith_s;
    bit_prop  = arith_r | arith_s;
    group_gp  = fbas_lookahead(bit_gen, bit_prop);
  end

  // ****************************************
  // function result
  // ****************************************
  always_comb begin
    alu_f = arith_sum[WORD_W-1:0];
    case (func_sel)
      FN_OR: begin
        alu_f = opnd_r | opnd_s;
      end
      FN_AND: begin
        alu_f = opnd_r & opnd_s;
      end
      FN_NOTRS: begin
        alu_f = ~opnd_r & opnd_s;
      end
      FN_XOR: begin
        alu_f = opnd_r ^ opnd_s;
      end
      FN_XNOR: begin
        alu_f = ~(opnd_r ^ opnd_s);
      end
      default: begin
        alu_f = arith_sum[WORD_W-1:0];
      end
    endcase
  end

  // ****************************************
  // status outputs
  // ****************************************
  // logic functions neither generate nor propagate a carry
  always_comb begin
    o_carry_output      = is_arith & arith_sum[WORD_W];
    o_carry_generate_b  = ~(is_arith & group_gp[1]);
    o_carry_propagate_b = ~(is_arith & group_gp[0]);
    o_overflow_flag     = is_arith & (carry_into_msb ^ arith_sum[WORD_W]);
    o_alu_sign          = alu_f[MSB];
  end

  // open collector: pull low while any result bit is set
  always_comb begin
    o_zero_detect    = 1'b0;
    o_zero_detect_oe = (alu_f != ZERO_WORD);
  end

  // ****************************************
  // destination decode
  // ****************************************
  // codes 6 and 7 mirror 4 and 5 in the up direction
  always_comb begin
    ram_wr    = 1'b1;
    ram_shift = SH_NONE;
    acc_mode  = QM_HOLD;
    y_from_a  = 1'b0;
    case (dest_sel)
      DST_QREG: begin
        ram_wr   = 1'b0;
        acc_mode = QM_LOAD;
      end
      DST_NOP: begin
        ram_wr = 1'b0;
      end
      DST_RAMA: begin
        y_from_a = 1'b1;
      end
      DST_RAMF: begin
        ram_shift = SH_NONE;
      end
      DST_RAMQD: begin
        ram_shift = SH_DOWN;
        acc_mode  = QM_DOWN;
      end
      DST_RAMD: begin
        ram_shift = SH_DOWN;
      end
      DST_RAMQU: begin
        ram_shift = SH_UP;
        acc_mode  = QM_UP;
      end
      default: begin
        ram_shift = SH_UP;
      end
    endcase
  end

  // ****************************************
  // stack write shifter
  // ****************************************
  // fill bits come from the neighbour through the released shift lines
  always_comb begin
    ram_wr_data = alu_f;
    case (ram_shift)
      SH_DOWN: begin
        ram_wr_data = {i_stack_msb_shift_line, alu_f[MSB:1]};
      end
      SH_UP: begin
        ram_wr_data = {alu_f[MSB-1:0], i_stack_lsb_shift_line};
      end
      default: begin
        ram_wr_data = alu_f;
      end
    endcase
  end

  // ****************************************
  // accumulator register
  // ****************************************
  // q shifts on its own lines so an alu op and a shift share one cycle
  always_comb begin
    acc_d = acc_q;
    case (acc_mode)
      QM_LOAD: begin
        acc_d = alu_f;
      end
      QM_DOWN: begin
        acc_d = {i_accumulator_msb_shift_line, acc_q[MSB:1]};
      end
      QM_UP: begin
        acc_d = {acc_q[MSB-1:0], i_accumulator_lsb_shift_line};
      end
      default: begin
        acc_d = acc_q;
      end
    endcase
  end

  // no reset: holds undefined contents until loaded
  always_ff @(posedge i_mclk) begin
    acc_q <= acc_d;
  end

  // ****************************************
  // shift pins
  // ****************************************
  // a line is driven only in the direction that shifts out of this slice;
  // otherwise the neighbour owns it and its level feeds the fill bit
  always_comb begin
    o_stack_msb_shift_line          = alu_f[MSB];
    o_stack_msb_shift_line_oe       = (ram_shift == SH_UP);
    o_accumulator_msb_shift_line    = acc_q[MSB];
    o_accumulator_msb_shift_line_oe = (ram_shift == SH_UP);
  end

  always_comb begin
    o_stack_lsb_shift_line          = alu_f[0];
    o_stack_lsb_shift_line_oe       = (ram_shift == SH_DOWN);
    o_accumulator_lsb_shift_line    = acc_q[0];
    o_accumulator_lsb_shift_line_oe = (ram_shift == SH_DOWN);
  end

  // ****************************************
  // result output
  // ****************************************
  // y stays combinational so a result is ready in the same cycle
  always_comb begin
    o_slice_result_out    = y_from_a ? port_a : alu_f;
    o_slice_result_out_oe = ~i_output_enable_b;
  end

endmodule // fbas_slice

//--- tb/fbas_far_model.sv
`timescale 1ns/10ps
// ****************************************
// neighbour slice end of one shared line
// ****************************************
module fbas_far_model (
  input  wire logic i_oe,
  input  wire logic i_drv,
  input  wire logic i_fill,
  output logic      o_lvl
);
  // neighbour drives its bit whenever the slice releases the line
  assign o_lvl = i_oe ? i_drv : i_fill;
endmodule // fbas_far_model

//--- tb/fbas_slice_sva.sv
`timescale 1ns/10ps
module fbas_slice_sva (
  input wire logic                         i_mclk,
  input wire logic [fbas_pkg::ADDR_W-1:0]  i_first_read_address,
  input wire logic [fbas_pkg::ADDR_W-1:0]  i_second_read_write_address,
  input wire logic [fbas_pkg::INSTR_W-1:0] i_microinstruction_word,
  input wire logic [fbas_pkg::WORD_W-1:0]  i_direct_operand_in,
  input wire logic                         i_carry_input,
  input wire logic                         i_output_enable_b,
  input wire logic                         o_stack_msb_shift_line,
  input wire logic                         o_stack_msb_shift_line_oe,
  input wire logic                         o_stack_lsb_shift_line,
  input wire logic                         o_stack_lsb_shift_line_oe,
  input wire logic [fbas_pkg::WORD_W-1:0]  o_slice_result_out,
  input wire logic                         o_slice_result_out_oe,
  input wire logic                         o_carry_output,
  input wire logic                         o_carry_generate_b,
  input wire logic                         o_carry_propagate_b,
  input wire logic                         o_overflow_flag,
  input wire logic                         o_alu_sign,
  input wire logic                         o_zero_detect_oe
);
  import fbas_pkg::*;
  wire [2:0] ds = i_microinstruction_word[8:6];
  wire [5:0] sf = i_microinstruction_word[5:0];
  default clocking cb @(posedge i_mclk); endclocking
  sequence s_wr; ds == DST_RAMF; endsequence
  sequence s_rd; sf == 6'h1c && ds != DST_RAMA && i_first_read_address == $past(i_second_read_write_address); endsequence
  sequence s_ql; ds == DST_QREG; endsequence
  sequence s_qr; sf == 6'h1a && ds != DST_RAMA; endsequence
  a_y_enable: assert property (o_slice_result_out_oe == !i_output_enable_b)
    else $error("y enable wrong");
  a_msb_release: assert property (o_stack_msb_shift_line_oe == (ds >= 3'h6))
    else $error("msb line enable wrong");
  a_msb_value: assert property (o_stack_msb_shift_line_oe |-> o_stack_msb_shift_line == o_alu_sign)
    else $error("msb line value wrong");
  a_lsb_release: assert property (o_stack_lsb_shift_line_oe == (ds == 3'h4 || ds == 3'h5))
    else $error("lsb line enable wrong");
  a_lsb_value: assert property (o_stack_lsb_shift_line_oe |-> o_stack_lsb_shift_line == o_slice_result_out[0])
    else $error("lsb line value wrong");
  a_zero_line: assert property (ds != DST_RAMA |-> o_zero_detect_oe == (o_slice_result_out != 4'h0))
    else $error("zero line wrong");
  a_logic_flags: assert property (sf[5:3] >= 3'h3 |-> !o_carry_output && !o_overflow_flag
    && o_carry_generate_b && o_carry_propagate_b)
    else $error("logic function flags active");
  a_add_direct: assert property (sf == 6'h07 && ds != DST_RAMA |->
    {o_carry_output, o_slice_result_out} == 5'(i_direct_operand_in) + i_carry_input)
    else $error("direct add wrong");
  a_stack_back: assert property (s_wr ##1 s_rd |-> o_slice_result_out == $past(o_slice_result_out))
    else $error("stack write back wrong");
  a_q_back: assert property (s_ql ##1 s_qr |-> o_slice_result_out == $past(o_slice_result_out))
    else $error("q load back wrong");
endmodule // fbas_slice_sva
bind fbas_slice fbas_slice_sva u_sva (.*);

//--- tb/test_fbas_slice.sv
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_fbas_slice;
  import fbas_pkg::*;
  logic               i_mclk;
  logic [3:0]         a, b, d, fill, qr;
  logic [8:0]         iw;
  logic               cn, oe_b;
  logic [3:0]         stk [16];
  logic [14:0]        notes [$];
  logic [14:0]        e;
  int                 mismatches, n_compared, seed = 9;
  wire  [3:0]         y;
  wire                sm, so, am, ao, lsm, lso, lam, lao, zo, zl;
  wire                co, gb, pb, ov, yoe, sml, aml, sll, all_l, sg, zd;
  fbas_slice uut (.i_mclk(i_mclk), .i_first_read_address(a), .i_second_read_write_address(b),
    .i_microinstruction_word(iw), .i_direct_operand_in(d), .i_carry_input(cn), .i_output_enable_b(oe_b),
    .i_stack_msb_shift_line(sml), .o_stack_msb_shift_line(sm), .o_stack_msb_shift_line_oe(so),
    .i_accumulator_msb_shift_line(aml), .o_accumulator_msb_shift_line(am), .o_accumulator_msb_shift_line_oe(ao),
    .i_stack_lsb_shift_line(sll), .o_stack_lsb_shift_line(lsm), .o_stack_lsb_shift_line_oe(lso),
    .i_accumulator_lsb_shift_line(all_l), .o_accumulator_lsb_shift_line(lam), .o_accumulator_lsb_shift_line_oe(lao),
    .o_slice_result_out(y), .o_slice_result_out_oe(yoe), .o_carry_output(co), .o_carry_generate_b(gb),
    .o_carry_propagate_b(pb), .o_overflow_flag(ov), .o_alu_sign(sg), .o_zero_detect(zd), .o_zero_detect_oe(zo));
  fbas_far_model u_sm (.i_oe(so), .i_drv(sm), .i_fill(fill[0]), .o_lvl(sml));
  fbas_far_model u_am (.i_oe(ao), .i_drv(am), .i_fill(fill[1]), .o_lvl(aml));
  fbas_far_model u_sl (.i_oe(lso), .i_drv(lsm), .i_fill(fill[2]), .o_lvl(sll));
  fbas_far_model u_al (.i_oe(lao), .i_drv(lam), .i_fill(fill[3]), .o_lvl(all_l));
  // open collector zero line with pull-up
  fbas_far_model u_zl (.i_oe(zo), .i_drv(zd), .i_fill(1'b1), .o_lvl(zl));
  initial begin
    i_mclk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) i_mclk = ~i_mclk;
  end
  // ****************************************
  // one microinstruction with its expected outcome
  // ****************************************
  task step(input logic [8:0] w, input logic [3:0] av, input logic [3:0] bv, input logic [3:0] dv);
    logic [3:0] r, s, f, rr, ss, pv, gv, lo;
    logic [4:0] sum;
    logic       ar, g, up, dn;
    @(posedge i_mclk);
    #1;
    iw = w; a = av; b = bv; d = dv;
    cn = 1'($random(seed)); oe_b = 1'($random(seed)); fill = 4'($random(seed));
    case (w[2:0])
      3'h0: {r, s} = {stk[a], qr};
      3'h1: {r, s} = {stk[a], stk[b]};
      3'h2: {r, s} = {4'h0, qr};
      3'h3: {r, s} = {4'h0, stk[b]};
      3'h4: {r, s} = {4'h0, stk[a]};
      3'h5: {r, s} = {d, stk[a]};
      3'h6: {r, s} = {d, qr};
      default: {r, s} = {d, 4'h0};
    endcase
    rr = (w[5:3] == 3'h1) ? ~r : r;
    ss = (w[5:3] == 3'h2) ? ~s : s;
    sum = 5'(rr) + 5'(ss) + 5'(cn);
    lo = 4'(rr[2:0]) + 4'(ss[2:0]) + 4'(cn);
    pv = rr | ss;
    gv = rr & ss;
    g = gv[3] | pv[3] & (gv[2] | pv[2] & (gv[1] | pv[1] & gv[0]));
    ar = w[5:3] < 3'h3;
    case (w[5:3])
      3'h0, 3'h1, 3'h2: f = sum[3:0];
      3'h3: f = r | s;
      3'h4: f = r & s;
      3'h5: f = ~r & s;
      3'h6: f = r ^ s;
      default: f = ~(r ^ s);
    endcase
    up = (w[8:7] == 2'h3);
    dn = (w[8:7] == 2'h2);
    notes.push_back({f[3], up ? f[3] : fill[0], up ? qr[3] : fill[1], dn ? f[0] : fill[2], dn ? qr[0] : fill[3],
      (w[8:6] == 3'h2) ? stk[a] : f, ar & sum[4], ar & (sum[4] ^ lo[3]), ~(ar & g), ~(ar & (&pv)),
      f == 4'h0, ~oe_b});
    case (w[8:6])
      3'h0: qr = f;
      3'h4: qr = {fill[1], qr[3:1]};
      3'h6: qr = {qr[2:0], fill[3]};
      default: ;
    endcase
    case (w[8:6])
      3'h2, 3'h3: stk[b] = f;
      3'h4, 3'h5: stk[b] = {fill[0], f[3:1]};
      3'h6, 3'h7: stk[b] = {f[2:0], fill[2]};
      default: ;
    endcase
  endtask
  always @(negedge i_mclk) begin
    if (notes.size() > 0) begin
      e = notes.pop_front();
      `CHK(y, e[9:6])
      `CHK({co, ov}, e[5:4])
      `CHK({gb, pb}, e[3:2])
      `CHK(zl, e[1])
      `CHK(yoe, e[0])
      `CHK({sg, sml, aml, sll, all_l}, e[14:10])
    end
  end
  task results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    iw = 9'h05f; a = 4'h0; b = 4'h0; d = 4'h0; cn = 1'b0; oe_b = 1'b1; fill = 4'h0; qr = 4'hx;
    repeat (5) @(posedge i_mclk);
    // stack and Q hold nothing defined until written
    for (int i = 0; i < 16; i++) step(9'h0df, 4'h0, 4'(i), 4'($random(seed)));
    step(9'h01f, 4'h0, 4'h0, 4'($random(seed)));
    repeat (24) begin
      b = 4'($random(seed));
      step({3'h3, 6'($random(seed))}, 4'($random(seed)), b, 4'($random(seed)));
      step(9'h05c, b, 4'($random(seed)), 4'($random(seed)));
      step({3'h0, 6'($random(seed))}, 4'($random(seed)), 4'($random(seed)), 4'($random(seed)));
      step(9'h05a, 4'($random(seed)), 4'($random(seed)), 4'($random(seed)));
    end
    repeat (600) step(9'($random(seed)), 4'($random(seed)), 4'($random(seed)), 4'($random(seed)));
    @(negedge i_mclk);
    @(negedge i_mclk);
    results();
  end
endmodule // test_fbas_slice
